// ### hdl/sdi_path_pkg.sv
// constants, field layout and carrier types for the serial video path control block
//=====================================================================
package sdi_path_pkg;

  //=====================================================================
  // register offsets
  localparam logic [7:0] ADDR_EQ_CH0 = 8'h00;
  localparam logic [7:0] ADDR_EQ_CH1 = 8'h01;
  localparam logic [7:0] ADDR_EQ_CH2 = 8'h02;
  localparam logic [7:0] ADDR_EQ_CH3 = 8'h03;
  localparam logic [7:0] ADDR_LOS_CFG = 8'h06;
  localparam logic [7:0] ADDR_IN_SEL = 8'h07;
  localparam logic [7:0] ADDR_OUT_A = 8'h09;
  localparam logic [7:0] ADDR_OUT_B_DE = 8'h0A;
  localparam logic [7:0] ADDR_OUT_B_SW = 8'h0B;
  localparam logic [7:0] ADDR_OUT_B_CTL = 8'h0C;
  localparam logic [7:0] ADDR_GBL_ONE = 8'h0D;
  localparam logic [7:0] ADDR_ALARM_STAT = 8'h10;
  localparam logic [7:0] ADDR_ALARM_CLR = 8'h85;

  //=====================================================================
  // field positions
  localparam int LOS_THR_LSB = 5;
  localparam int LOS_MUTE_OFF_BIT = 3;
  localparam int CLK_OUT_BIT = 0;
  localparam int SWING_LSB = 2;
  localparam int DE_A_LSB = 0;
  localparam int DE_B_LSB = 4;
  localparam int OUT_B_EN_BIT = 2;
  localparam int DC_OFF_BIT = 1;
  localparam int ALL_PWR_BIT = 3;
  localparam int CLR_BIT = 0;
  localparam int STAT_HW_BIT = 4;

  // three-level pin slots
  localparam int PIN_MODE = 0;
  localparam int PIN_EQ = 1;
  localparam int PIN_DE = 2;
  localparam int PIN_OUTB = 3;

  //=====================================================================
  // level codes and reset values
  localparam logic [1:0] LEVEL_NONE = 2'h0;
  localparam logic [1:0] LEVEL_MED = 2'h2;
  localparam logic [1:0] LEVEL_HIGH = 2'h3;
  localparam logic [1:0] SWING_TOP = 2'h2;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [2:0] RST_THR = 3'h0;

  typedef enum logic [1:0] {
    PIN_LOW = 2'b00,
    PIN_FLOAT = 2'b01,
    PIN_HIGH = 2'b10
  } pin_level_e;

  typedef struct packed {
    logic [3:0][1:0] eq_level;
    logic [2:0] los_threshold;
    logic dc_loop_off;
    logic [1:0] route_sel;
    logic [3:0] input_power;
    logic [3:0] input_mute;
    logic out_b_enable;
    logic out_b_clock;
    logic [1:0] swing_a;
    logic [1:0] swing_b;
    logic [1:0] deemph_a;
    logic [1:0] deemph_b;
    logic [3:0] alarm;
    logic hw_mode;
  } analog_ctrl_s;

endpackage

// ### hdl/sdi_path_control.sv
// register bank and pin decode steering the serial video data path
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module sdi_path_control
  import sdi_path_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [3:0] I_TRI_ABOVE,
  input wire logic [3:0] I_TRI_BELOW,
  input wire logic [3:0] I_AMP_BELOW,
  input wire logic [3:0] I_AMP_ABOVE,
  output logic [7:0] O_RDATA,
  output analog_ctrl_s O_CTRL
);

  //=====================================================================
  // state
  typedef struct packed {
    logic [3:0][1:0] eq;
    logic [2:0] los_thr;
    logic mute_off;
    logic clk_out;
    logic [1:0] sel;
    logic [1:0] swing_a;
    logic [1:0] deemph_a;
    logic [1:0] deemph_b;
    logic [1:0] swing_b;
    logic out_b_en;
    logic dc_off;
    logic all_pwr;
    logic clr;
    logic [3:0] tri_hi_s1;
    logic [3:0] tri_hi_s2;
    logic [3:0] tri_lo_s1;
    logic [3:0] tri_lo_s2;
    logic [3:0] below_s1;
    logic [3:0] below_s2;
    logic [3:0] above_s1;
    logic [3:0] above_s2;
    logic [3:0] loss;
    logic [3:0] alarm;
    logic [1:0] warm;
    logic [7:0] rdata;
    analog_ctrl_s ctrl;
  } state_s;

  state_s st;
  state_s next_st;

  // comparator pair to three-level state; floating = neither comparator trips
  function automatic pin_level_e decode_pin(input logic hi, input logic lo);
    pin_level_e lvl;
    lvl = PIN_FLOAT;
    if (hi) begin
      lvl = PIN_HIGH;
    end else if (lo) begin
      lvl = PIN_LOW;
    end
    return lvl;
  endfunction

  // pin level to two-bit code; the pins offer no lowest nonzero step
  function automatic logic [1:0] pin_code(input pin_level_e lvl);
    logic [1:0] code;
    code = LEVEL_NONE;
    case (lvl)
      PIN_HIGH: code = LEVEL_HIGH;
      PIN_FLOAT: code = LEVEL_MED;
      default: code = LEVEL_NONE;
    endcase
    return code;
  endfunction

  pin_level_e lvl_mode;
  pin_level_e lvl_eq;
  pin_level_e lvl_de;
  pin_level_e lvl_outb;
  logic hw;
  logic [3:0] powered;
  logic clear_now;

  //=====================================================================
  // next state
  always_comb begin
    next_st = st;
    lvl_mode = decode_pin(st.tri_hi_s2[PIN_MODE], st.tri_lo_s2[PIN_MODE]);
    lvl_eq = decode_pin(st.tri_hi_s2[PIN_EQ], st.tri_lo_s2[PIN_EQ]);
    lvl_de = decode_pin(st.tri_hi_s2[PIN_DE], st.tri_lo_s2[PIN_DE]);
    lvl_outb = decode_pin(st.tri_hi_s2[PIN_OUTB], st.tri_lo_s2[PIN_OUTB]);
    // synchronisers reset to zero, which reads as floating; wait until they hold real pin levels
    next_st.warm = st.warm[1] ? st.warm : st.warm + 2'h1;
    hw = st.warm[1] & (lvl_mode == PIN_FLOAT);

    // pins and analog comparators are asynchronous to the clock
    next_st.tri_hi_s1 = I_TRI_ABOVE;
    next_st.tri_hi_s2 = st.tri_hi_s1;
    next_st.tri_lo_s1 = I_TRI_BELOW;
    next_st.tri_lo_s2 = st.tri_lo_s1;
    next_st.below_s1 = I_AMP_BELOW;
    next_st.below_s2 = st.below_s1;
    next_st.above_s1 = I_AMP_ABOVE;
    next_st.above_s2 = st.above_s1;

    // register writes
    clear_now = 1'b0;
    if (I_WR) begin
      case (I_ADDR)
        ADDR_EQ_CH0: next_st.eq[0] = I_WDATA[1:0];
        ADDR_EQ_CH1: next_st.eq[1] = I_WDATA[1:0];
        ADDR_EQ_CH2: next_st.eq[2] = I_WDATA[1:0];
        ADDR_EQ_CH3: next_st.eq[3] = I_WDATA[1:0];
        ADDR_LOS_CFG: begin
          next_st.los_thr = I_WDATA[LOS_THR_LSB +: 3];
          next_st.mute_off = I_WDATA[LOS_MUTE_OFF_BIT];
          next_st.clk_out = I_WDATA[CLK_OUT_BIT];
        end
        ADDR_IN_SEL: next_st.sel = I_WDATA[1:0];
        ADDR_OUT_A: begin
          next_st.swing_a = I_WDATA[SWING_LSB +: 2];
          next_st.deemph_a = I_WDATA[DE_A_LSB +: 2];
        end
        ADDR_OUT_B_DE: next_st.deemph_b = I_WDATA[DE_B_LSB +: 2];
        ADDR_OUT_B_SW: next_st.swing_b = I_WDATA[SWING_LSB +: 2];
        ADDR_OUT_B_CTL: next_st.out_b_en = I_WDATA[OUT_B_EN_BIT];
        ADDR_GBL_ONE: begin
          next_st.dc_off = I_WDATA[DC_OFF_BIT];
          next_st.all_pwr = I_WDATA[ALL_PWR_BIT];
        end
        ADDR_ALARM_CLR: begin
          next_st.clr = I_WDATA[CLR_BIT];
          // clear acts on the falling edge of the bit, i.e. the low write
          clear_now = st.clr & ~I_WDATA[CLR_BIT];
        end
        default: ;
      endcase
    end

    // only the routed input is powered unless all are kept up
    powered = 4'h0;
    powered[st.sel] = 1'b1;
    if (st.all_pwr) begin
      powered = 4'hF;
    end

    // hysteresis: set below low threshold, release above high one or when the input is unpowered
    for (int i = 0; i < 4; i++) begin
      if (!powered[i]) begin
        next_st.loss[i] = 1'b0;
      end else if (st.below_s2[i]) begin
        next_st.loss[i] = 1'b1;
      end else if (st.above_s2[i]) begin
        next_st.loss[i] = 1'b0;
      end
    end

    // set wins over clear so no loss event is dropped
    next_st.alarm = (clear_now ? 4'h0 : st.alarm) | st.loss;

    // analog control outputs
    next_st.ctrl.hw_mode = hw;
    next_st.ctrl.los_threshold = st.los_thr;
    next_st.ctrl.dc_loop_off = st.dc_off;
    next_st.ctrl.route_sel = st.sel;
    next_st.ctrl.input_power = powered;
    next_st.ctrl.alarm = st.alarm;
    next_st.ctrl.input_mute = st.mute_off ? 4'h0 : st.alarm;
    // code three is not a swing step; hold it at the top level
    next_st.ctrl.swing_a = (st.swing_a > SWING_TOP) ? SWING_TOP : st.swing_a;
    next_st.ctrl.swing_b = (st.swing_b > SWING_TOP) ? SWING_TOP : st.swing_b;
    if (hw) begin
      for (int i = 0; i < 4; i++) begin
        next_st.ctrl.eq_level[i] = pin_code(lvl_eq);
      end
      next_st.ctrl.deemph_a = pin_code(lvl_de);
      next_st.ctrl.deemph_b = pin_code(lvl_de);
      next_st.ctrl.out_b_enable = (lvl_outb != PIN_LOW);
      next_st.ctrl.out_b_clock = (lvl_outb == PIN_HIGH);
    end else begin
      next_st.ctrl.eq_level = st.eq;
      next_st.ctrl.deemph_a = st.deemph_a;
      next_st.ctrl.deemph_b = st.deemph_b;
      next_st.ctrl.out_b_enable = st.out_b_en;
      next_st.ctrl.out_b_clock = st.clk_out;
    end

    // read data stands only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        ADDR_EQ_CH0: next_st.rdata = {6'h00, st.eq[0]};
        ADDR_EQ_CH1: next_st.rdata = {6'h00, st.eq[1]};
        ADDR_EQ_CH2: next_st.rdata = {6'h00, st.eq[2]};
        ADDR_EQ_CH3: next_st.rdata = {6'h00, st.eq[3]};
        ADDR_LOS_CFG: next_st.rdata = {st.los_thr, 1'b0, st.mute_off, 2'h0, st.clk_out};
        ADDR_IN_SEL: next_st.rdata = {6'h00, st.sel};
        ADDR_OUT_A: next_st.rdata = {4'h0, st.swing_a, st.deemph_a};
        ADDR_OUT_B_DE: next_st.rdata = {2'h0, st.deemph_b, 4'h0};
        ADDR_OUT_B_SW: next_st.rdata = {4'h0, st.swing_b, 2'h0};
        ADDR_OUT_B_CTL: next_st.rdata = {5'h00, st.out_b_en, 2'h0};
        ADDR_GBL_ONE: next_st.rdata = {4'h0, st.all_pwr, 1'b0, st.dc_off, 1'b0};
        ADDR_ALARM_CLR: next_st.rdata = {7'h00, st.clr};
        ADDR_ALARM_STAT: next_st.rdata = {3'h0, hw, st.alarm};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  //=====================================================================
  // registers
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= '0;
      st.eq <= {4{RST_LEVEL}};
      st.los_thr <= RST_THR;
      st.sel <= RST_SEL;
      st.ctrl.route_sel <= RST_SEL;
      st.ctrl.input_power <= 4'h1;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_CTRL = st.ctrl;

endmodule

// ### dv/sdi_far_side.sv
// far-side model: three-level pin drivers and input amplitude detectors
`timescale 1ns/10ps
module sdi_far_side
  import sdi_path_pkg::*;
(
  input wire logic [3:0][1:0] i_pin,
  input wire logic [3:0][3:0] i_amp,
  output logic [3:0] o_above,
  output logic [3:0] o_below,
  output logic [3:0] o_amp_below,
  output logic [3:0] o_amp_above
);
  //=========
  // sensing
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_above[k] = i_pin[k] == PIN_HIGH;
      o_below[k] = i_pin[k] == PIN_LOW; // undriven pin senses neither
      o_amp_below[k] = i_amp[k] < 4'h4;
      o_amp_above[k] = i_amp[k] > 4'h9; // gap gives hysteresis
    end
  end
endmodule

// ### dv/sdi_path_control_sva.sv
// port checker for the path control block
`timescale 1ns/10ps
module sdi_path_control_sva
  import sdi_path_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [3:0] I_TRI_ABOVE,
  input wire logic [3:0] I_TRI_BELOW,
  input wire logic [3:0] I_AMP_BELOW,
  input wire logic [3:0] I_AMP_ABOVE,
  input wire logic [7:0] O_RDATA,
  input wire analog_ctrl_s O_CTRL
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  sequence loss_held;
    (I_AMP_BELOW[0] && O_CTRL.input_power[0]) [*6];
  endsequence
  sequence mode_float;
    (!I_TRI_ABOVE[PIN_MODE] && !I_TRI_BELOW[PIN_MODE]) [*6];
  endsequence
  //=========
  // checks
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00) else $error("rdata not idle");
  eq_write_a: assert property (I_WR && I_ADDR == ADDR_EQ_CH0 && !O_CTRL.hw_mode |->
    ##2 O_CTRL.eq_level[0] == $past(I_WDATA[1:0], 2)) else $error("eq not applied");
  dc_write_a: assert property (I_WR && I_ADDR == ADDR_GBL_ONE |->
    ##2 O_CTRL.dc_loop_off == $past(I_WDATA[DC_OFF_BIT], 2)) else $error("dc loop wrong");
  sel_power_a: assert property (O_CTRL.input_power[O_CTRL.route_sel])
    else $error("routed input off");
  mute_alarm_a: assert property ((O_CTRL.input_mute & ~O_CTRL.alarm) == 4'h0)
    else $error("mute without alarm");
  swing_clamp_a: assert property (O_CTRL.swing_a != 2'h3 && O_CTRL.swing_b != 2'h3)
    else $error("bad swing");
  alarm_set_a: assert property (loss_held |-> O_CTRL.alarm[0])
    else $error("alarm not set");
  alarm_hold_a: assert property ($fell(O_CTRL.alarm[0]) |->
    $past(I_WR && I_ADDR == ADDR_ALARM_CLR, 2)) else $error("alarm dropped");
  hw_mode_a: assert property (mode_float |-> O_CTRL.hw_mode)
    else $error("no hw mode");
  hw_eq_a: assert property ((O_CTRL.hw_mode && I_TRI_ABOVE[PIN_EQ]) [*6] |->
    O_CTRL.eq_level == {4{LEVEL_HIGH}}) else $error("hw eq wrong");
  hw_outb_a: assert property ((O_CTRL.hw_mode && I_TRI_ABOVE[PIN_OUTB]) [*6] |->
    O_CTRL.out_b_enable && O_CTRL.out_b_clock) else $error("hw out b wrong");
endmodule
bind sdi_path_control sdi_path_control_sva u_sva (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_TRI_ABOVE(I_TRI_ABOVE),
  .I_TRI_BELOW(I_TRI_BELOW), .I_AMP_BELOW(I_AMP_BELOW), .I_AMP_ABOVE(I_AMP_ABOVE),
  .O_RDATA(O_RDATA), .O_CTRL(O_CTRL));

// ### dv/sdi_path_control_bench.sv
// self-checking bench for the path control block
`timescale 1ns/10ps
module sdi_path_control_bench;
  import sdi_path_pkg::*;
  logic I_MCLK, I_RST_N, I_WR, I_RD;
  logic [7:0] I_ADDR, I_WDATA, O_RDATA, q, d;
  logic [3:0] I_TRI_ABOVE, I_TRI_BELOW, I_AMP_BELOW, I_AMP_ABOVE;
  logic [3:0][1:0] pin;
  logic [3:0][3:0] amp;
  analog_ctrl_s O_CTRL, e;
  int n_errors, checks_done, seed;
  sdi_path_control u_dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_TRI_ABOVE(I_TRI_ABOVE),
    .I_TRI_BELOW(I_TRI_BELOW), .I_AMP_BELOW(I_AMP_BELOW), .I_AMP_ABOVE(I_AMP_ABOVE),
    .O_RDATA(O_RDATA), .O_CTRL(O_CTRL));
  sdi_far_side u_far (.i_pin(pin), .i_amp(amp), .o_above(I_TRI_ABOVE),
    .o_below(I_TRI_BELOW), .o_amp_below(I_AMP_BELOW), .o_amp_above(I_AMP_ABOVE));
  initial begin
    I_MCLK = 1'b0;
    forever #50 I_MCLK = ~I_MCLK;
  end
  //=========
  // helpers
  task automatic chk(input string n, input logic [39:0] s, x);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_WDATA <= v;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 q = O_RDATA;
  endtask
  // whole control word against the running expectation
  task automatic see(input int w);
    repeat (w) @(posedge I_MCLK);
    #1 chk("ctrl", 40'(O_CTRL), 40'(e));
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [1:0] hw_code(input logic [1:0] p);
    return p == PIN_LOW ? LEVEL_NONE : p == PIN_FLOAT ? LEVEL_MED : LEVEL_HIGH;
  endfunction
  function automatic logic [1:0] clamp(input logic [1:0] v);
    return v == 2'h3 ? SWING_TOP : v;
  endfunction
  initial begin
    #100000 n_errors++;
    end_sim();
  end
  //=========
  // sequence
  initial begin
    {I_RST_N, I_WR, I_RD, I_ADDR, I_WDATA} = '0;
    n_errors = 0;
    checks_done = 0;
    seed = 32'h92F71DBF;
    pin = {4{PIN_HIGH}};
    amp = {4{4'hC}};
    e = '0;
    e.input_power = 4'h1;
    see(12);
    @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      d = 8'($random(seed));
      wr(ADDR_EQ_CH0 + 8'(c), d);
      e.eq_level[c] = d[1:0];
      rd(ADDR_EQ_CH0 + 8'(c));
      chk("eq read", 40'(q), 40'(d & 8'h03));
    end
    for (int s = 0; s < 4; s++) begin
      d = s == 3 ? 8'hFF : s == 0 ? 8'h00 : 8'($random(seed));
      wr(ADDR_IN_SEL, 8'(s));
      wr(ADDR_GBL_ONE, d);
      wr(ADDR_OUT_A, d);
      wr(ADDR_OUT_B_SW, ~d);
      wr(ADDR_OUT_B_DE, d);
      wr(ADDR_OUT_B_CTL, d);
      wr(ADDR_LOS_CFG, d);
      e.route_sel = 2'(s);
      e.dc_loop_off = d[DC_OFF_BIT];
      e.input_power = d[ALL_PWR_BIT] ? 4'hF : 4'(4'h1 << s);
      {e.swing_a, e.deemph_a} = {clamp(d[3:2]), d[1:0]};
      {e.swing_b, e.deemph_b} = {clamp(~d[3:2]), d[5:4]};
      {e.out_b_enable, e.los_threshold} = {d[OUT_B_EN_BIT], d[7:5]};
      e.out_b_clock = d[CLK_OUT_BIT];
      see(2);
    end
    rd(8'h40);
    chk("unmapped", 40'(q), 40'h0);
    wr(ADDR_IN_SEL, 8'h00);
    wr(ADDR_GBL_ONE, 8'h00);
    wr(ADDR_LOS_CFG, 8'h00);
    amp <= {4{4'h1}};
    {e.route_sel, e.input_power, e.dc_loop_off} = {2'h0, 4'h1, 1'b0};
    {e.los_threshold, e.out_b_clock, e.alarm, e.input_mute} = {3'h0, 1'b0, 4'h1, 4'h1};
    see(8);
    rd(ADDR_ALARM_STAT);
    chk("status", 40'(q), 40'h01);
    amp[0] <= 4'h6;
    wr(ADDR_ALARM_CLR, 8'h01);
    wr(ADDR_ALARM_CLR, 8'h00);
    see(4);
    amp <= {4{4'hC}};
    wr(ADDR_LOS_CFG, 8'h08);
    e.input_mute = 4'h0;
    see(8);
    wr(ADDR_ALARM_CLR, 8'h01);
    wr(ADDR_ALARM_CLR, 8'h00);
    e.alarm = 4'h0;
    see(3);
    for (int k = 0; k < 3; k++) begin
      pin <= {{3{2'(k)}}, PIN_FLOAT};
      e.hw_mode = 1'b1;
      e.eq_level = {4{hw_code(2'(k))}};
      {e.deemph_a, e.deemph_b} = {2{hw_code(2'(k))}};
      {e.out_b_enable, e.out_b_clock} = {k != 0, k == 2};
      see(8);
    end
    end_sim();
  end
endmodule
